// File: rtl/rhm_pkg.sv
// rhm_pkg: constants, states and carrier structs for reset/halt mode control.
// assumes a 40 MHz processor clock (mclk).
package rhm_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 25;
    localparam int PWRUP_CYCLES     = 8;    // power-up reset length, cycles
    localparam int FLOAT_CYCLES     = 8;    // float pin hold before outputs tri-state
    localparam int HALT_WIN_CYCLES  = 10;   // re-assert window for halt-after-reset
    localparam int SEQ_CYCLES       = 2;    // call slot plus nop slot
    localparam int CNT_W            = 4;

    // ----------------------------------------------------------------
    // sequencer encodings
    // ----------------------------------------------------------------
    localparam logic [23:0] SEQ_CALL_ADDR = 24'h000000;
    localparam logic [4:0]  SEQ_LINK_REG  = 5'h0E;
    localparam int          RUN_BIT       = 0;

    typedef enum logic [1:0] {
        RHM_INSN_NONE,
        RHM_INSN_NOP,
        RHM_INSN_CALL
    } rhm_insn_t;

    typedef enum logic [2:0] {
        RHM_ST_RESET,
        RHM_ST_SEQ_CALL,
        RHM_ST_SEQ_NOP,
        RHM_ST_RUN,
        RHM_ST_HALT
    } rhm_state_t;

    // synchronised pin levels and reset-request edges
    typedef struct packed {
        logic float_n;
        logic reset_req_n;
        logic reset_req_rise;
        logic reset_req_fall;
    } rhm_pins_t;

    // injected instruction toward the core
    typedef struct packed {
        rhm_insn_t   kind;
        logic [23:0] addr;
        logic [4:0]  link_reg;
    } rhm_inject_t;

endpackage : rhm_pkg

// File: rtl/rhm_pin_sync.sv
// rhm_pin_sync: three-stage synchroniser for the two control pins.
// assumes pins are asynchronous to mclk; a change counts once stages 2 and 3 agree.
`timescale 1ns/10ps
module rhm_pin_sync (
    input  wire logic               mclk,      // processor clock
    input  wire logic               srst,      // sync reset, active high
    input  wire logic               float_n_i, // raw float pin
    input  wire logic               rreq_n_i,  // raw reset-request pin
    output rhm_pkg::rhm_pins_t      pins_o     // filtered levels and edges
);
    import rhm_pkg::*;

    logic [2:0] fl_r;
    logic [2:0] rq_r;
    logic       fl_st_r;
    logic       rq_st_r;
    logic       rq_prev_r;

    // ----------------------------------------------------------------
    // sample chains
    // ----------------------------------------------------------------
    // pins synchronised first
    always_ff @(posedge mclk) begin
        if (srst) begin
            fl_r <= 3'h7;
            rq_r <= 3'h7;
        end else begin
            fl_r <= {fl_r[1:0], float_n_i};
            rq_r <= {rq_r[1:0], rreq_n_i};
        end
    end

    // stage 1 is read only by stage 2; stable value follows 2 and 3 agreeing
    always_ff @(posedge mclk) begin
        if (srst) begin
            fl_st_r   <= 1'b1;
            rq_st_r   <= 1'b1;
            rq_prev_r <= 1'b1;
        end else begin
            if (fl_r[1] == fl_r[2]) begin
                fl_st_r <= fl_r[2];
            end
            if (rq_r[1] == rq_r[2]) begin
                rq_st_r <= rq_r[2];
            end
            rq_prev_r <= rq_st_r;
        end
    end

    assign pins_o.float_n        = fl_st_r;
    assign pins_o.reset_req_n    = rq_st_r;
    assign pins_o.reset_req_rise = rq_st_r & ~rq_prev_r;
    assign pins_o.reset_req_fall = ~rq_st_r & rq_prev_r;

endmodule : rhm_pin_sync

// File: rtl/rhm_ctrl.sv
// rhm_ctrl: reset state, reset sequence, halt and run mode control.
// assumes srst models power application; run bit write arrives as a one-cycle strobe.
//
// Behaviour
// - both pins low forces reset state
// - reset-request rising edge enters reset
// - run bit rise resets only if pin high
// - eight cycles of reset after power-up
// - reset exit runs call 0 then nop
// - halt issues nops, host DMA stays on
// - post power-up pin decode picks reset/run/halt
// - run to halt on pin low or bit 0
// - reset-request pin overrides the run bit
// - leave halt via reset and sequence
// - both pins low behaves as power-up
// - re-assert within ten cycles halts cleanly
// - float over eight cycles tri-states outputs
`timescale 1ns/10ps
module rhm_ctrl #(
    parameter int PWRUP_N = rhm_pkg::PWRUP_CYCLES,   // power-up reset cycles
    parameter int FLOAT_N = rhm_pkg::FLOAT_CYCLES,   // float hold before tri-state
    parameter int HALT_N  = rhm_pkg::HALT_WIN_CYCLES // halt re-assert window
) (
    input  wire logic                 mclk,          // processor clock
    input  wire logic                 srst,          // power-on reset, active high
    input  wire logic                 float_n_i,     // float pin, active low
    input  wire logic                 rreq_n_i,      // reset-request pin, active low
    input  wire logic                 run_wr_i,      // run-control bit write strobe
    input  wire logic                 run_wdata_i,   // value written to run bit
    output rhm_pkg::rhm_inject_t      inject_o,      // injected instruction
    output logic                      core_reset_o,  // internal reset state
    output logic                      fetch_en_o,    // core fetches own program
    output logic                      halted_o,      // halt mode indicator
    output logic                      dma_en_o,      // host port DMA allowed
    output logic                      outputs_oe_o,  // high: outputs driven
    output logic                      run_bit_o      // run-control bit readback
);
    import rhm_pkg::*;

    rhm_pins_t   pins;
    rhm_state_t  st_r;
    rhm_state_t  st_nxt;
    logic [CNT_W-1:0] pwr_cnt_r;
    logic [CNT_W-1:0] flt_cnt_r;
    logic [CNT_W-1:0] win_cnt_r;
    logic        halt_tgt_r;
    logic        run_bit_r;
    logic        run_rise;
    logic        both_low;
    logic        enter_reset;
    logic        pwr_busy;
    logic        halt_req;

    rhm_pin_sync u_sync (
        .mclk      (mclk),
        .srst      (srst),
        .float_n_i (float_n_i),
        .rreq_n_i  (rreq_n_i),
        .pins_o    (pins)
    );

    // ----------------------------------------------------------------
    // run-control bit
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            run_bit_r <= 1'b0;
        end else if (run_wr_i) begin
            run_bit_r <= run_wdata_i;
        end
    end

    assign run_rise = run_wr_i & run_wdata_i & ~run_bit_r;
    assign both_low = ~pins.float_n & ~pins.reset_req_n;
    assign pwr_busy = (pwr_cnt_r != '0);

    assign enter_reset = both_low | pins.reset_req_rise | (run_rise & pins.reset_req_n);

    // pin decides; bit only counts while pin is high
    assign halt_req = ~pins.reset_req_n | (run_wr_i & ~run_wdata_i);

    // ----------------------------------------------------------------
    // power-up counter
    // ----------------------------------------------------------------
    // eight-cycle reset, restarted while both pins low
    always_ff @(posedge mclk) begin
        if (srst || both_low) begin
            pwr_cnt_r <= CNT_W'(PWRUP_N);
        end else if (pwr_busy) begin
            pwr_cnt_r <= pwr_cnt_r - CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // halt target: where the sequence ends
    // ----------------------------------------------------------------
    // window after a deassert; re-assert inside it means halt
    always_ff @(posedge mclk) begin
        if (srst) begin
            win_cnt_r <= '0;
        end else if (pins.reset_req_rise) begin
            win_cnt_r <= CNT_W'(HALT_N);
        end else if (win_cnt_r != '0) begin
            win_cnt_r <= win_cnt_r - CNT_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            halt_tgt_r <= 1'b0;
        end else if (st_r == RHM_ST_RESET && pwr_cnt_r == CNT_W'(1)) begin
            // decode pins as power-up period ends
            halt_tgt_r <= ~pins.reset_req_n;
        end else if (enter_reset) begin
            halt_tgt_r <= 1'b0;
        end else if (pins.reset_req_fall && win_cnt_r != '0) begin
            halt_tgt_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // mode state machine
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            RHM_ST_RESET: begin
                if (!pwr_busy && !both_low && !enter_reset) begin
                    st_nxt = RHM_ST_SEQ_CALL;
                end
            end
            RHM_ST_SEQ_CALL: begin
                st_nxt = RHM_ST_SEQ_NOP;
            end
            RHM_ST_SEQ_NOP: begin
                // a pending halt skips the first fetch
                // nops repeat while the re-assert window is open, so a late re-assert
                // never lets a fetch slip through; costs a few cycles before run
                if (halt_tgt_r || !pins.reset_req_n) begin
                    st_nxt = RHM_ST_HALT;
                end else if (win_cnt_r == '0) begin
                    st_nxt = RHM_ST_RUN;
                end
            end
            RHM_ST_RUN: begin
                if (halt_req) begin
                    st_nxt = RHM_ST_HALT;
                end
            end
            RHM_ST_HALT: begin
                // exit halt through reset when pin goes high or bit set while pin high
                if (pins.reset_req_rise || (run_rise && pins.reset_req_n)) begin
                    st_nxt = RHM_ST_RESET;
                end
            end
        endcase
        if (enter_reset) begin
            st_nxt = RHM_ST_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r <= RHM_ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // float pin timer
    // ----------------------------------------------------------------
    // saturating count of float-asserted cycles
    always_ff @(posedge mclk) begin
        if (srst || pins.float_n) begin
            flt_cnt_r <= '0;
        end else if (flt_cnt_r != CNT_W'(FLOAT_N)) begin
            flt_cnt_r <= flt_cnt_r + CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            inject_o     <= '{kind: RHM_INSN_NONE, addr: SEQ_CALL_ADDR, link_reg: SEQ_LINK_REG};
            core_reset_o <= 1'b1;
            fetch_en_o   <= 1'b0;
            halted_o     <= 1'b0;
            dma_en_o     <= 1'b0;
            outputs_oe_o <= 1'b1;
            run_bit_o    <= 1'b0;
        end else begin
            inject_o.addr     <= SEQ_CALL_ADDR;
            inject_o.link_reg <= SEQ_LINK_REG;
            unique case (st_nxt)
                // call 0 linking through register fourteen
                RHM_ST_SEQ_CALL: inject_o.kind <= RHM_INSN_CALL;
                RHM_ST_SEQ_NOP,
                RHM_ST_HALT:     inject_o.kind <= RHM_INSN_NOP;
                default:         inject_o.kind <= RHM_INSN_NONE;
            endcase
            core_reset_o <= (st_nxt == RHM_ST_RESET);
            fetch_en_o   <= (st_nxt == RHM_ST_RUN);
            halted_o     <= (st_nxt == RHM_ST_HALT);
            // host DMA keeps running in halt
            dma_en_o     <= (st_nxt == RHM_ST_RUN) || (st_nxt == RHM_ST_HALT);
            // tri-state once float held past limit
            outputs_oe_o <= ~(flt_cnt_r == CNT_W'(FLOAT_N) && !pins.float_n);
            run_bit_o    <= run_wr_i ? run_wdata_i : run_bit_r;
        end
    end

endmodule : rhm_ctrl

// File: sim/rhm_ctrl_checker.sv
// rhm_ctrl_checker: timing properties of the reset/halt mode controller.
// assumes it is bound onto rhm_ctrl; pins reach the decode some five edges late.
`timescale 1ns/10ps
module rhm_ctrl_checker
    import rhm_pkg::*;
#(
    parameter int FLOAT_N = FLOAT_CYCLES  // float hold before tri-state
) (
    input logic          mclk,        // clock
    input logic          srst,        // reset
    input logic          float_n_i,   // float pin
    input logic          rreq_n_i,    // reset-request pin
    input logic          run_wr_i,    // run bit strobe
    input logic          run_wdata_i, // run bit value
    input rhm_inject_t   inject_o,    // injected insn
    input logic          core_reset_o, // reset state
    input logic          fetch_en_o,  // run mode
    input logic          halted_o,    // halt mode
    input logic          dma_en_o,    // dma allowed
    input logic          outputs_oe_o, // outputs driven
    input logic          run_bit_o    // run bit
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic [4:0] flo_r;
    logic [4:0] rlo_r;
    // saturating counts of cycles each pin has been low
    always_ff @(posedge mclk) begin
        flo_r <= (srst || float_n_i) ? 5'h00 : flo_r + {4'h0, flo_r != 5'h1F};
        rlo_r <= (srst || rreq_n_i) ? 5'h00 : rlo_r + {4'h0, rlo_r != 5'h1F};
    end
    a_powerup_hold: assert property ($fell(srst) |-> core_reset_o [*8])
        else $error("reset state shorter than power-up count");
    a_both_low_reset: assert property ((!float_n_i && !rreq_n_i) [*8] |-> core_reset_o)
        else $error("both pins low without reset state");
    a_call_first: assert property ($fell(core_reset_o) |-> inject_o.kind == RHM_INSN_CALL
        && inject_o.addr == SEQ_CALL_ADDR && inject_o.link_reg == SEQ_LINK_REG)
        else $error("reset exit without call to zero");
    a_nop_follows: assert property (inject_o.kind == RHM_INSN_CALL |=> inject_o.kind == RHM_INSN_NOP)
        else $error("call not followed by nop");
    a_halt_nops_only: assert property (halted_o |-> inject_o.kind == RHM_INSN_NOP
        && !fetch_en_o && dma_en_o)
        else $error("halt mode not issuing nops with dma on");
    a_run_to_halt: assert property (fetch_en_o && run_wr_i && !run_wdata_i |=> halted_o && !fetch_en_o)
        else $error("run bit cleared without halt");
    a_pin_wins: assert property (rlo_r > 5'h05 && float_n_i && halted_o && run_wr_i
        |=> halted_o)
        else $error("run bit overrode asserted reset-request pin");
    a_bit_rise_reset: assert property (halted_o && run_wr_i && run_wdata_i && !run_bit_o
        && rreq_n_i && $past(rreq_n_i, 6) |-> ##[1:2] core_reset_o)
        else $error("run bit rise did not reset");
    a_pin_rise_reset: assert property ($rose(rreq_n_i) && float_n_i && halted_o
        |-> ##[2:8] core_reset_o)
        else $error("reset-request rise did not reset");
    a_float_hiz: assert property (flo_r == FLOAT_N + 8 |-> !outputs_oe_o)
        else $error("long float without tri-state");
    c_run: cover property ($rose(fetch_en_o));
    c_halt: cover property ($rose(halted_o));
    c_hiz: cover property ($fell(outputs_oe_o));
endmodule : rhm_ctrl_checker

bind rhm_ctrl rhm_ctrl_checker #(.FLOAT_N(FLOAT_N)) i_chk (.mclk, .srst, .float_n_i,
    .rreq_n_i, .run_wr_i, .run_wdata_i, .inject_o, .core_reset_o, .fetch_en_o,
    .halted_o, .dma_en_o, .outputs_oe_o, .run_bit_o);

// File: sim/rhm_pins_model.sv
// rhm_pins_model: external system controller driving the float and reset-request pins.
// assumes commands arrive at mclk edges; lag makes the controller slow.
`timescale 1ns/10ps
module rhm_pins_model (
    input  logic       mclk,    // clock
    input  logic [1:0] want,    // wanted {float_n, rreq_n}
    input  int         lag,     // reaction delay, cycles
    output logic       float_n, // float pin
    output logic       rreq_n   // reset-request pin
);
    int wait_r = 0;
    initial {float_n, rreq_n} = 2'b11;
    always @(posedge mclk) begin
        if ({float_n, rreq_n} === want) begin
            wait_r <= 0;
        end else if (wait_r >= lag) begin
            {float_n, rreq_n} <= want;
        end else begin
            wait_r <= wait_r + 1;
        end
    end
endmodule : rhm_pins_model

// File: sim/rhm_ctrl_tb.sv
// rhm_ctrl_tb: directed scenarios for reset, halt and run control.
// assumes a partner model for the pins and the checker bound to the design.
`timescale 1ns/10ps
module rhm_ctrl_tb;
    import rhm_pkg::*;
    localparam logic [3:0] ST_RUN = 4'h5, ST_HALT = 4'h3, ST_RST = 4'h8;
    logic        mclk, srst, run_wr_i, run_wdata_i, float_n, rreq_n;
    logic        core_reset, fetch_en, halted, dma_en, oe, run_bit;
    logic [1:0]  want;
    int          lag, errors, check_count, cyc;
    rhm_inject_t inject;
    wire  [3:0]  st = {core_reset, fetch_en, halted, dma_en};

    rhm_pins_model i_pins (.mclk(mclk), .want(want), .lag(lag), .float_n(float_n),
        .rreq_n(rreq_n));
    rhm_ctrl i_dut (.mclk(mclk), .srst(srst), .float_n_i(float_n), .rreq_n_i(rreq_n),
        .run_wr_i(run_wr_i), .run_wdata_i(run_wdata_i), .inject_o(inject),
        .core_reset_o(core_reset), .fetch_en_o(fetch_en), .halted_o(halted),
        .dma_en_o(dma_en), .outputs_oe_o(oe), .run_bit_o(run_bit));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    // modes settle through the pin synchroniser, so wait with a bound
    task automatic wait_st(input logic [3:0] e);
        for (int i = 0; i < 60 && st !== e; i++) tick(1);
        chk({28'h0, st}, {28'h0, e});
    endtask : wait_st
    task automatic pins(input logic [1:0] v, input int l);
        @(posedge mclk);
        want <= v;
        lag  <= l;
    endtask : pins
    task automatic wr_run(input logic v);
        @(posedge mclk);
        run_wr_i    <= 1'b1;
        run_wdata_i <= v;
        @(posedge mclk);
        run_wr_i    <= 1'b0;
        tick(1);
    endtask : wr_run
    task automatic boot(input logic [1:0] v);
        @(posedge mclk);
        srst <= 1'b1;
        want <= v;
        lag  <= 0;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        tick(6);
        chk({31'h0, core_reset}, 32'h1);
    endtask : boot
    task automatic t_boot_modes();
        boot(2'b11);
        wait_st(ST_RUN);
        boot(2'b10);
        wait_st(ST_HALT);
        chk({30'h0, inject.kind}, {30'h0, RHM_INSN_NOP});
        boot(2'b00);
        tick(30);
        chk({28'h0, st}, {28'h0, ST_RST});
        pins(2'b11, 2);
        wait_st(ST_RUN);
    endtask : t_boot_modes
    task automatic t_bit_mode();
        wr_run(1'b0);
        wait_st(ST_HALT);
        wr_run(1'b1);
        wait_st(ST_RUN);
        chk({31'h0, run_bit}, 32'h1);
    endtask : t_bit_mode
    task automatic t_pin_mode();
        pins(2'b10, 3);
        wait_st(ST_HALT);
        wr_run(1'b0);
        wr_run(1'b1);
        tick(5);
        chk({28'h0, st}, {28'h0, ST_HALT});
        pins(2'b11, 0);
        wait_st(ST_RUN);
    endtask : t_pin_mode
    task automatic t_quick_halt();
        logic ran;
        ran = 1'b0;
        pins(2'b10, 0);
        wait_st(ST_HALT);
        pins(2'b11, 0);
        tick(3);
        pins(2'b10, 0);
        repeat (40) begin
            tick(1);
            ran |= fetch_en;
        end
        chk({31'h0, ran}, 32'h0);
        chk({28'h0, st}, {28'h0, ST_HALT});
    endtask : t_quick_halt
    task automatic t_float();
        pins(2'b11, 0);
        wait_st(ST_RUN);
        pins(2'b01, 0);
        tick(24);
        chk({31'h0, oe}, 32'h0);
        pins(2'b00, 1);
        wait_st(ST_RST);
        pins(2'b11, 0);
        wait_st(ST_RUN);
        chk({31'h0, oe}, 32'h1);
    endtask : t_float
    task automatic tally_and_finish();
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        {srst, run_wr_i, run_wdata_i, want, lag} = {3'b100, 2'b11, 32'h0};
        {errors, check_count, cyc} = '0;
        t_boot_modes();
        t_bit_mode();
        t_pin_mode();
        t_quick_halt();
        t_float();
        tally_and_finish();
    end
endmodule : rhm_ctrl_tb
